// ### logic/idwu_pkg.sv
// constants shared by both ends of the idle and wake-up controller
package idwu_pkg;

	// ----------------------------------------------------------------
	// device register map, word index on the device link
	// ----------------------------------------------------------------
	localparam logic [15:0] DOMAIN_IDLE_CONFIG  = 16'h0001;
	localparam logic [15:0] DOMAIN_IDLE_STATUS  = 16'h0002;
	localparam logic [15:0] PERIPH_IDLE_CONTROL = 16'h9400;
	localparam logic [15:0] PERIPH_IDLE_STATUS  = 16'h9401;
	localparam logic [15:0] MASTER_IDLE_CONTROL = 16'h9402;
	localparam logic [15:0] MASTER_IDLE_STATUS  = 16'h9403;
	localparam logic [15:0] PLL_CTRL_STATUS     = 16'h9404;
	localparam logic [15:0] WAKE_SOURCE_ENABLE  = 16'h9405;
	localparam logic [15:0] IRQ_ENABLE          = 16'h9406;
	localparam logic [15:0] REG_RESET           = 16'h0000;

	// ----------------------------------------------------------------
	// domain idle config / status bit positions
	// ----------------------------------------------------------------
	localparam int CORE_IDLE_BIT       = 0;
	localparam int MASTER_PORT_IDLE    = 1;
	localparam int ICACHE_IDLE_BIT     = 2;
	localparam int PERIPH_DOMAIN_IDLE  = 3;
	localparam int CLKGEN_IDLE_BIT     = 4;
	localparam int MEMIF_IDLE_BIT      = 5;
	localparam int EXT_PORT_IDLE_BIT   = 6;
	localparam int MEM_PORT_IDLE_BIT   = 7;
	localparam int INSTR_PORT_IDLE_BIT = 8;
	localparam int CLKGEN_EXT_IDLE_BIT = 9;
	localparam int DOMAIN_BITS         = 10;
	localparam logic [15:0] CONFIG_WMASK   = 16'h03FF;
	localparam logic [15:0] CLKGEN_REQ_SET = 16'h03E7;
	localparam logic [15:0] WAKE_CLR_MASK  = 16'h0171;

	// ----------------------------------------------------------------
	// peripheral, master and clock register fields
	// ----------------------------------------------------------------
	localparam int PERIPH_SERIAL_BIT = 0;
	localparam int PERIPH_MEMIF_BIT  = 9;
	localparam int MASTER_DMA_BIT    = 0;
	localparam int MASTER_HOST_BIT   = 1;
	localparam int PLL_PWRDN_BIT     = 0;
	localparam int PLL_RESET_BIT     = 1;
	localparam int PLL_ENABLE_BIT    = 2;
	localparam int OSC_PWRDN_BIT     = 3;
	localparam int PLL_LOCK_BIT      = 4;
	localparam logic [15:0] PLL_WMASK  = 16'h000F;
	localparam logic [15:0] PLL_RESET  = 16'h0002;
	localparam int WAKE_NMI_BIT      = 4;
	localparam int OSC_STABLE_CYCLES = 41032;

	// ----------------------------------------------------------------
	// controller APB register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CTL_ADDR   = 8'h00;
	localparam logic [7:0] CTL_WDATA  = 8'h04;
	localparam logic [7:0] CTL_CMD    = 8'h08;
	localparam logic [7:0] CTL_STATUS = 8'h0C;
	localparam logic [7:0] CTL_RDATA  = 8'h10;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT  = 1;
	localparam int CMD_IDLE_BIT  = 2;
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_ERR_BIT   = 1;

endpackage

// ### logic/idwu_link_if.sv
// link between the software-side controller and the idle/wake device
`timescale 1ns/10ps
interface idwu_link_if;
	logic        regWr;    // one-cycle write request
	logic        regRd;    // one-cycle read request
	logic [15:0] regAddr;  // device register index
	logic [15:0] regWdata; // write data
	logic        idleExec; // one-cycle idle instruction strobe
	logic        regAck;   // one-cycle answer
	logic        regErr;   // answer to an unmapped index
	logic [15:0] regRdata; // read data, valid with regAck

	modport dev (input regWr, regRd, regAddr, regWdata, idleExec,
		output regAck, regErr, regRdata);
	modport ctl (output regWr, regRd, regAddr, regWdata, idleExec,
		input regAck, regErr, regRdata);
endinterface

// ### logic/idwu_device.sv
// idle and wake-up device: domain gating, wake sources, oscillator settle
`timescale 1ns/10ps

// Functional notes
// - enabled external irq or nmi wakes core
// - reset: all active, config/status cleared
// - core wake also wakes memif and partners
// - clear master-port bit, idle: dma+host wake
// - master control bit zero wakes that module
// - clear periph bit, idle: all peripherals wake
// - periph control bit zero wakes that peripheral, unless the write meets a core wake in the same cycle
// - all config zero plus idle: everything runs
// - pll enable selects pll core clock
// - wake restarts oscillator with clock module
// - wake enable selects wake-capable sources
// - software enables irqs before deep idle
// - count 41032 reference cycles after oscillator power-down wake/reset
// - idle instruction loads status from config
// - core off: any unmasked irq wakes
// - clock off: only wake-enabled external irq or nmi wakes
// - serial transfer auto-wakes serial and dma
// - memif unselected is gated, access errors
// - control writes that set bits wait for idle instruction
// - status registers show idle portions
// - config is 16 bits, top six reserved
// - bad clock-idle combination raises bus error
module idwu_device
	import idwu_pkg::*;
#(
	parameter int STABLE_CYCLES = OSC_STABLE_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	idwu_link_if.dev         link,
	input  wire logic [3:0]  extIrqPin,
	input  wire logic        nmiPin,
	input  wire logic        onChipIrq,
	input  wire logic        serialExtClk,
	input  wire logic        serialXferPin,
	input  wire logic        pllLockPin,
	input  wire logic        extBusSelMemif,
	input  wire logic        memifAccess,
	output logic [9:0]       domainClkEn,
	output logic [15:0]      periphClkEn,
	output logic [1:0]       masterClkEn,
	output logic             oscRun,
	output logic             pllSelect,
	output logic             cpuRun,
	output logic             busErrIrq
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);

	logic [15:0]   domainIdleConfig;
	logic [15:0]   domainIdleStatus;
	logic [15:0]   periphIdleControl;
	logic [15:0]   periphIdleStatus;
	logic [1:0]    masterIdleControl;
	logic [1:0]    masterIdleStatus;
	logic [15:0]   pllCtrlStatus;
	logic [4:0]    wakeSourceEnable;
	logic [3:0]    irqEnable;
	logic [CW-1:0] stableCnt;
	logic [6:0]    pinMeta;
	logic [6:0]    pinSync;
	logic          autoWake;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two stages before any wake logic looks at a pin
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {pllLockPin, serialXferPin, nmiPin, extIrqPin};
			pinSync <= pinMeta;
		end
	end

	wire [3:0] extIrq     = pinSync[3:0];
	wire       nmi        = pinSync[4];
	wire       serialXfer = pinSync[5];
	wire       pllLock    = pinSync[6];

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire wrCfg  = link.regWr && (link.regAddr == DOMAIN_IDLE_CONFIG);
	wire wrPic  = link.regWr && (link.regAddr == PERIPH_IDLE_CONTROL);
	wire wrMic  = link.regWr && (link.regAddr == MASTER_IDLE_CONTROL);
	wire wrPll  = link.regWr && (link.regAddr == PLL_CTRL_STATUS);
	wire wrWake = link.regWr && (link.regAddr == WAKE_SOURCE_ENABLE);
	wire wrIrq  = link.regWr && (link.regAddr == IRQ_ENABLE);
	wire mapped = (link.regAddr == DOMAIN_IDLE_CONFIG) || (link.regAddr == DOMAIN_IDLE_STATUS)
		|| (link.regAddr == PERIPH_IDLE_CONTROL) || (link.regAddr == PERIPH_IDLE_STATUS)
		|| (link.regAddr == MASTER_IDLE_CONTROL) || (link.regAddr == MASTER_IDLE_STATUS)
		|| (link.regAddr == PLL_CTRL_STATUS) || (link.regAddr == WAKE_SOURCE_ENABLE)
		|| (link.regAddr == IRQ_ENABLE);

	// read mux, status words show live idle state
	wire [15:0] pllView = {11'h000, pllLock, pllCtrlStatus[3:0]};
	wire [15:0] rdMux =
		(link.regAddr == DOMAIN_IDLE_CONFIG)  ? domainIdleConfig :
		(link.regAddr == DOMAIN_IDLE_STATUS)  ? domainIdleStatus :
		(link.regAddr == PERIPH_IDLE_CONTROL) ? periphIdleControl :
		(link.regAddr == PERIPH_IDLE_STATUS)  ? periphIdleStatus :
		(link.regAddr == MASTER_IDLE_CONTROL) ? {14'h0000, masterIdleControl} :
		(link.regAddr == MASTER_IDLE_STATUS)  ? {14'h0000, masterIdleStatus} :
		(link.regAddr == PLL_CTRL_STATUS)     ? pllView :
		(link.regAddr == WAKE_SOURCE_ENABLE)  ? {11'h000, wakeSourceEnable} :
		(link.regAddr == IRQ_ENABLE)          ? {12'h000, irqEnable} : 16'h0000;

	// ----------------------------------------------------------------
	// idle entry and wake conditions
	// ----------------------------------------------------------------
	// clock generator idle needs the whole set of port bits
	wire clkgenBad = domainIdleConfig[CLKGEN_IDLE_BIT]
		&& ((domainIdleConfig & CLKGEN_REQ_SET) != CLKGEN_REQ_SET);
	wire idleGo    = link.idleExec && !clkgenBad;

	wire coreOff   = domainIdleStatus[CORE_IDLE_BIT];
	wire clkOff    = domainIdleStatus[CLKGEN_IDLE_BIT];
	wire extWake   = |(extIrq & irqEnable) || nmi;
	// with the clock generator stopped only selected pins can wake
	wire deepWake  = |({nmi, extIrq} & wakeSourceEnable & {1'b1, irqEnable});
	wire wakeNow   = coreOff && (clkOff ? deepWake : (extWake || onChipIrq));
	wire oscDown   = clkOff && pllCtrlStatus[OSC_PWRDN_BIT];
	wire pllLive   = pllCtrlStatus[PLL_ENABLE_BIT] && !pllCtrlStatus[PLL_PWRDN_BIT];

	// serial transfer on external clock briefly ungates serial and dma
	wire nextAuto  = serialExtClk && pllLive && serialXfer
		&& periphIdleStatus[PERIPH_SERIAL_BIT] && masterIdleStatus[MASTER_DMA_BIT];

	// ----------------------------------------------------------------
	// staged control registers
	// ----------------------------------------------------------------
	// writes stage values; gating follows the idle strobe, except control bits cleared to zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			domainIdleConfig  <= REG_RESET;
			periphIdleControl <= REG_RESET;
			masterIdleControl <= '0;
			pllCtrlStatus     <= PLL_RESET;
			wakeSourceEnable  <= '0;
			irqEnable         <= '0;
		end else begin
			if (wrCfg)
				domainIdleConfig <= link.regWdata & CONFIG_WMASK;
			if (wrPic)
				periphIdleControl <= link.regWdata;
			if (wrMic)
				masterIdleControl <= link.regWdata[1:0];
			if (wrPll)
				pllCtrlStatus <= link.regWdata & PLL_WMASK;
			if (wrWake)
				wakeSourceEnable <= link.regWdata[4:0];
			if (wrIrq)
				irqEnable <= link.regWdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// active idle state
	// ----------------------------------------------------------------
	// wake clears only the core-related bits, config is untouched
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			domainIdleStatus <= REG_RESET;
			periphIdleStatus <= REG_RESET;
			masterIdleStatus <= '0;
		end else if (idleGo) begin
			domainIdleStatus <= domainIdleConfig;
			periphIdleStatus <= domainIdleConfig[PERIPH_DOMAIN_IDLE]
				? periphIdleControl : 16'h0000;
			masterIdleStatus <= domainIdleConfig[MASTER_PORT_IDLE]
				? masterIdleControl : 2'b00;
		end else begin
			if (wakeNow) begin
				domainIdleStatus <= domainIdleStatus & ~WAKE_CLR_MASK;
				periphIdleStatus[PERIPH_MEMIF_BIT] <= 1'b0;
			end else if (wrPic)
				periphIdleStatus <= periphIdleStatus & link.regWdata;
			if (wrMic)
				masterIdleStatus <= masterIdleStatus & link.regWdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// oscillator settle counter
	// ----------------------------------------------------------------
	// runs from reset, reloads when waking from oscillator power-down
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			stableCnt <= CW'(STABLE_CYCLES);
		else if (wakeNow && oscDown)
			stableCnt <= CW'(STABLE_CYCLES);
		else if (stableCnt != '0)
			stableCnt <= stableCnt - CW'(1);
	end

	// ----------------------------------------------------------------
	// registered outputs and link answer
	// ----------------------------------------------------------------
	wire memifSel = extBusSelMemif && !periphIdleStatus[PERIPH_MEMIF_BIT]
		&& !domainIdleStatus[MEMIF_IDLE_BIT];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			domainClkEn   <= '1;
			periphClkEn   <= '1;
			masterClkEn   <= '1;
			oscRun        <= 1'b1;
			pllSelect     <= 1'b0;
			cpuRun        <= 1'b0;
			busErrIrq     <= 1'b0;
			autoWake      <= 1'b0;
			link.regAck   <= 1'b0;
			link.regErr   <= 1'b0;
			link.regRdata <= 16'h0000;
		end else begin
			autoWake      <= nextAuto;
			domainClkEn   <= ~domainIdleStatus[DOMAIN_BITS-1:0];
			periphClkEn   <= ~periphIdleStatus | {15'h0000, autoWake};
			periphClkEn[PERIPH_MEMIF_BIT] <= memifSel;
			masterClkEn   <= ~masterIdleStatus | {1'b0, autoWake};
			oscRun        <= !oscDown;
			pllSelect     <= pllLive;
			cpuRun        <= (stableCnt == '0) && !coreOff;
			busErrIrq     <= (link.idleExec && clkgenBad) || (memifAccess && !memifSel);
			link.regAck   <= link.regWr || link.regRd;
			link.regErr   <= (link.regWr || link.regRd) && !mapped;
			link.regRdata <= link.regRd ? rdMux : 16'h0000;
		end
	end

endmodule // idwu_device

// ### logic/idwu_controller.sv
// software-side controller: APB slave that drives the device link
`timescale 1ns/10ps
module idwu_controller
	import idwu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	idwu_link_if.ctl         link
);
	logic        busy;
	logic        errFlag;
	logic [15:0] rdData;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire setup   = psel && !penable && !pready;
	wire access  = psel && penable && pready;
	wire wrEv    = access && pwrite;
	wire cmdWr   = wrEv && (paddr == CTL_CMD) && !busy;
	wire goWr    = cmdWr && pwdata[CMD_WRITE_BIT];
	wire goRd    = cmdWr && !pwdata[CMD_WRITE_BIT] && pwdata[CMD_READ_BIT];
	wire goIdle  = cmdWr && pwdata[CMD_IDLE_BIT] && !pwdata[CMD_WRITE_BIT]
		&& !pwdata[CMD_READ_BIT];
	wire errClr  = wrEv && (paddr == CTL_STATUS) && pwdata[STS_ERR_BIT];
	wire known   = (paddr == CTL_ADDR) || (paddr == CTL_WDATA) || (paddr == CTL_CMD)
		|| (paddr == CTL_STATUS) || (paddr == CTL_RDATA);
	wire [31:0] rdMux =
		(paddr == CTL_ADDR)   ? {16'h0000, link.regAddr} :
		(paddr == CTL_WDATA)  ? {16'h0000, link.regWdata} :
		(paddr == CTL_STATUS) ? {30'h00000000, errFlag, busy} :
		(paddr == CTL_RDATA)  ? {16'h0000, rdData} : 32'h00000000;

	// ----------------------------------------------------------------
	// APB answer: one wait-free access phase after setup
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= (setup && !pwrite) ? rdMux : 32'h00000000;
			pslverr <= setup && !known;
		end
	end

	// ----------------------------------------------------------------
	// link requests and status
	// ----------------------------------------------------------------
	// one request in flight; an error set beats a software clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			link.regAddr  <= 16'h0000;
			link.regWdata <= 16'h0000;
			link.regWr    <= 1'b0;
			link.regRd    <= 1'b0;
			link.idleExec <= 1'b0;
			busy          <= 1'b0;
			errFlag       <= 1'b0;
			rdData        <= 16'h0000;
		end else begin
			if (wrEv && (paddr == CTL_ADDR) && !busy)
				link.regAddr <= pwdata[15:0];
			if (wrEv && (paddr == CTL_WDATA) && !busy)
				link.regWdata <= pwdata[15:0];
			link.regWr    <= goWr;
			link.regRd    <= goRd;
			link.idleExec <= goIdle;
			if (goWr || goRd)
				busy <= 1'b1;
			else if (link.regAck)
				busy <= 1'b0;
			if (link.regAck && link.regErr)
				errFlag <= 1'b1;
			else if (errClr)
				errFlag <= 1'b0;
			if (link.regAck)
				rdData <= link.regRdata;
		end
	end

endmodule // idwu_controller

// ### tb/idwu_link_props.sv
// assertions on the link between the controller and the device
`timescale 1ns/10ps
module idwu_link_props
	import idwu_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        idleExec,
	input wire logic        regAck,
	input wire logic        regErr,
	input wire logic [15:0] regRdata
);
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	logic [15:0] cfgShadow; // last config value written
	logic        idleSeen;  // an idle strobe since reset
	wire         req    = regWr | regRd;
	wire         mapped = regAddr inside {DOMAIN_IDLE_CONFIG, DOMAIN_IDLE_STATUS,
		PERIPH_IDLE_CONTROL, PERIPH_IDLE_STATUS, MASTER_IDLE_CONTROL, MASTER_IDLE_STATUS,
		PLL_CTRL_STATUS, WAKE_SOURCE_ENABLE, IRQ_ENABLE};

	// config only changes by a write, never by wake or idle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfgShadow <= 16'h0000;
			idleSeen  <= 1'h0;
		end else begin
			if (regWr && regAddr == DOMAIN_IDLE_CONFIG)
				cfgShadow <= regWdata & CONFIG_WMASK;
			if (idleExec)
				idleSeen <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	a_ack_follows_req: assert property (req |=> regAck)
		else $error("link request left unanswered");
	a_ack_has_cause: assert property (regAck |-> $past(req))
		else $error("link answer without request");
	a_err_unmapped: assert property (req && !mapped |=> regErr)
		else $error("unmapped index not refused");
	a_no_err_mapped: assert property (req && mapped |=> !regErr)
		else $error("mapped index refused");
	a_err_with_ack: assert property (regErr |-> regAck)
		else $error("error flag outside an answer");
	a_rdata_quiet: assert property (!regAck |-> regRdata == 16'h0000)
		else $error("read data outside an answer");
	a_single_request: assert property (req |=> !req)
		else $error("second request before answer");
	a_idle_no_ack: assert property (idleExec && !req |=> !regAck)
		else $error("idle strobe answered");
	a_config_read: assert property (regRd && regAddr == DOMAIN_IDLE_CONFIG
		|=> regRdata == cfgShadow)
		else $error("config read differs from last write");
	a_status_reset: assert property (regRd && regAddr == DOMAIN_IDLE_STATUS && !idleSeen
		|=> regRdata == 16'h0000)
		else $error("status not clear before idle");
endmodule // idwu_link_props

// ### tb/idle_domain_wakeup_ctrl_bench.sv
// bench for the idle and wake-up controller with both ends joined
`timescale 1ns/10ps
module idle_domain_wakeup_ctrl_bench
	import idwu_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int STB = 16; // short settle count
	logic        mclk, rstn;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, lastErr;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  extIrq = 4'h0;
	logic        nmi = 1'h0, onChip = 1'h0, serClk = 1'h0, serXfer = 1'h0;
	logic        pllLock = 1'h0, busSel = 1'h1, memAcc = 1'h0, rdPend = 1'h0;
	logic [9:0]  domainClkEn;
	logic [15:0] periphClkEn;
	logic [1:0]  masterClkEn;
	logic        oscRun, pllSelect, cpuRun, busErrIrq;
	logic [16:0] expQ[$];
	int          badCount = 0, checksDone = 0, errCnt = 0;
	idwu_link_if linkBus();
	idwu_controller i_idwu_controller (.mclk(mclk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .link(linkBus));
	idwu_device #(.STABLE_CYCLES(STB)) i_idwu_device (.mclk(mclk), .rstn(rstn),
		.link(linkBus), .extIrqPin(extIrq), .nmiPin(nmi), .onChipIrq(onChip),
		.serialExtClk(serClk), .serialXferPin(serXfer), .pllLockPin(pllLock),
		.extBusSelMemif(busSel), .memifAccess(memAcc), .domainClkEn(domainClkEn),
		.periphClkEn(periphClkEn), .masterClkEn(masterClkEn), .oscRun(oscRun),
		.pllSelect(pllSelect), .cpuRun(cpuRun), .busErrIrq(busErrIrq));
	idwu_link_props i_idwu_link_props (.mclk(mclk), .rstn(rstn), .regWr(linkBus.regWr),
		.regRd(linkBus.regRd), .regAddr(linkBus.regAddr), .regWdata(linkBus.regWdata),
		.idleExec(linkBus.idleExec), .regAck(linkBus.regAck), .regErr(linkBus.regErr),
		.regRdata(linkBus.regRdata));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finalReport();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		@(posedge mclk);
		while (!pready) @(posedge mclk);
		q = prdata;
		lastErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	// one device request through the controller, polled until done
	task automatic devReq(input logic [2:0] cmd, input logic [15:0] a, input logic [15:0] d);
		logic [31:0] q;
		apb(1'h1, CTL_ADDR, {16'h0, a}, q);
		apb(1'h1, CTL_WDATA, {16'h0, d}, q);
		apb(1'h1, CTL_CMD, {29'h0, cmd}, q);
		q = 32'h1;
		while (q[STS_BUSY_BIT]) apb(1'h0, CTL_STATUS, 32'h0, q);
	endtask
	task automatic devWr(input logic [15:0] a, input logic [15:0] d);
		devReq(3'h1, a, d);
	endtask
	task automatic devRd(input logic [15:0] a, input logic [16:0] exp);
		expQ.push_back(exp);
		devReq(3'h2, a, 16'h0);
	endtask
	task automatic devIdle();
		devReq(3'h4, 16'h0, 16'h0);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic settle(input string what);
		int n;
		n = 0;
		while (!cpuRun && n < 100) begin
			@(posedge mclk);
			n++;
		end
		check(what, 32'(n <= STB + 3), 32'h1);
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and result monitor
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		tick(30000);
		badCount++;
		$display("watchdog expired");
		finalReport();
	end
	// takes the oldest expected read whenever a read answer appears
	always @(posedge mclk) begin
		if (busErrIrq)
			errCnt++;
		if (linkBus.regRd)
			rdPend <= 1'h1;
		if (linkBus.regAck && rdPend) begin
			rdPend <= 1'h0;
			if (expQ.size() == 0)
				check("unexpected read", 32'h1, 32'h0);
			else
				check("link read", {linkBus.regErr, linkBus.regRdata}, expQ.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] v, st;
		logic [31:0] q;
		int n;
		rstn = 1'h0;
		void'($urandom(32'hE7B0));
		tick(3);
		rstn <= 1'h1;
		check("run at reset", cpuRun, 1'h0);
		settle("reset settle");
		check("reset gates", {domainClkEn, masterClkEn, periphClkEn}, 28'hFFFFFFF);
		devRd(DOMAIN_IDLE_CONFIG, 17'h0);
		devRd(DOMAIN_IDLE_STATUS, 17'h0);
		devRd(PERIPH_IDLE_STATUS, 17'h0);
		devRd(MASTER_IDLE_STATUS, 17'h0);
		devRd(PLL_CTRL_STATUS, 17'h00002);
		apb(1'h0, CTL_RDATA, 32'h0, q);
		check("read data reg", q, 32'h00000002);
		devRd(16'h0003, 17'h10000);
		apb(1'h0, CTL_STATUS, 32'h0, q);
		check("error flag", q, 32'h00000002);
		apb(1'h1, CTL_STATUS, 32'h00000002, q);
		apb(1'h0, CTL_STATUS, 32'h0, q);
		check("error cleared", q, 32'h00000000);
		apb(1'h0, 8'h14, 32'h0, q);
		check("apb unmapped", lastErr, 1'h1);
		$display("test reset done");
		devWr(IRQ_ENABLE, 16'h000F);
		// status left by the previous wake stays until the next idle strobe
		st = 16'h0000;
		for (int s = 0; s < 3; s++) begin
			v = 16'($urandom() & 32'h03EF) | 16'h0001;
			devWr(DOMAIN_IDLE_CONFIG, v);
			devRd(DOMAIN_IDLE_STATUS, {1'h0, st});
			check("staged gates", domainClkEn, 10'(~st[9:0]));
			devIdle();
			tick(3);
			check("idle gates", domainClkEn, 10'(~v[9:0]));
			check("core stopped", cpuRun, 1'h0);
			devRd(DOMAIN_IDLE_STATUS, {1'h0, v});
			nmi <= (s == 0);
			onChip <= (s == 1);
			extIrq <= {3'h0, s == 2};
			tick(6);
			nmi <= 1'h0;
			onChip <= 1'h0;
			extIrq <= 4'h0;
			check("core woken", cpuRun, 1'h1);
			st = v & ~WAKE_CLR_MASK;
			devRd(DOMAIN_IDLE_STATUS, {1'h0, st});
			devRd(DOMAIN_IDLE_CONFIG, {1'h0, v});
		end
		$display("test core wake done");
		devWr(MASTER_IDLE_CONTROL, 16'h0003);
		devWr(PERIPH_IDLE_CONTROL, 16'h0201);
		devWr(DOMAIN_IDLE_CONFIG, 16'h000A);
		devIdle();
		tick(3);
		devRd(MASTER_IDLE_STATUS, 17'h00003);
		devRd(PERIPH_IDLE_STATUS, 17'h00201);
		check("master gated", masterClkEn, 2'h0);
		// auto wake needs the pll running and not powered down
		devWr(PLL_CTRL_STATUS, 16'h0004);
		serClk <= 1'h1;
		serXfer <= 1'h1;
		tick(6);
		check("auto wake", {periphClkEn[0], masterClkEn[0]}, 2'h3);
		serXfer <= 1'h0;
		tick(6);
		check("auto idle", {periphClkEn[0], masterClkEn[0]}, 2'h0);
		devWr(MASTER_IDLE_CONTROL, 16'h0002);
		devRd(MASTER_IDLE_STATUS, 17'h00002);
		devWr(PERIPH_IDLE_CONTROL, 16'h0001);
		devRd(PERIPH_IDLE_STATUS, 17'h00001);
		busSel <= 1'h0;
		n = errCnt;
		memAcc <= 1'h1;
		tick(1);
		memAcc <= 1'h0;
		tick(4);
		check("memif unselected", periphClkEn[9], 1'h0);
		check("memif access", errCnt, n + 1);
		busSel <= 1'h1;
		devWr(DOMAIN_IDLE_CONFIG, 16'h0000);
		devIdle();
		tick(3);
		check("all running", {domainClkEn, masterClkEn, periphClkEn}, 28'hFFFFFFF);
		n = errCnt;
		devWr(DOMAIN_IDLE_CONFIG, 16'h0010);
		devIdle();
		tick(4);
		check("clock idle alone", errCnt, n + 1);
		devRd(DOMAIN_IDLE_STATUS, 17'h0);
		$display("test domains done");
		devWr(WAKE_SOURCE_ENABLE, 16'h0002);
		devWr(PLL_CTRL_STATUS, 16'h0009);
		devWr(DOMAIN_IDLE_CONFIG, 16'h03FF);
		devIdle();
		tick(4);
		check("osc stopped", oscRun, 1'h0);
		extIrq <= 4'h1;
		tick(8);
		check("source not enabled", oscRun, 1'h0);
		extIrq <= 4'h2;
		tick(6);
		extIrq <= 4'h0;
		check("osc restarted", oscRun, 1'h1);
		check("settle running", cpuRun, 1'h0);
		settle("wake settle");
		devRd(DOMAIN_IDLE_STATUS, {1'h0, 16'h03FF & ~WAKE_CLR_MASK});
		devRd(DOMAIN_IDLE_CONFIG, 17'h003FF);
		devWr(DOMAIN_IDLE_CONFIG, 16'h0000);
		devIdle();
		pllLock <= 1'h1;
		devWr(PLL_CTRL_STATUS, 16'h0000);
		devRd(PLL_CTRL_STATUS, 17'h00010);
		check("pll not chosen", pllSelect, 1'h0);
		devWr(PLL_CTRL_STATUS, 16'h0004);
		tick(3);
		check("pll chosen", pllSelect, 1'h1);
		check("deep exit", {domainClkEn, masterClkEn}, 12'hFFF);
		$display("test deep idle done");
		finalReport();
	end
endmodule // idle_domain_wakeup_ctrl_bench
